/* rtl/mac_if_pkg.sv */
/*
 * Shared constants and carriers for the MAC-side data interface of a 10/100 PHY.
 * Assumes one core clock of 40 MHz; the link reference clock is sampled, not used as a clock.
 */
package mac_if_pkg;
	// Core clock and nibble timing
	localparam int CLK_PERIOD_NS    = 25;
	localparam int REF_PERIOD_NS    = 20;
	localparam int SLOW_HOLD_REFS   = 10;
	localparam int MII_DIV_100      = 1;
	localparam int MII_DIV_10       = 10;
	// Carrier detection window at 100 Mbps
	localparam int CARRIER_WIN_BITS = 10;
	localparam int CARRIER_ZEROES   = 2;
	// Receive elasticity buffer
	localparam int FIFO_WIDTH       = 4;
	localparam int FIFO_DEPTH       = 32;
	// Reset values
	localparam logic RST_DUPLEX     = 1'b0;
	localparam logic RST_SPEED_100  = 1'b1;

	// One received nibble with its error flag
	typedef struct packed {
		logic       err;
		logic [3:0] data;
	} rx_word_s;

	// Transmit nibble as seen from the MAC
	typedef struct packed {
		logic       en;
		logic       err;
		logic [3:0] data;
	} tx_word_s;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_WAIT  = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_DRAIN = 4'b1000
	} rx_state_e;
endpackage

/* rtl/sync2.sv */
/*
 * Two-flop synchroniser for a bus of levels.
 * Assumes the input is quasi-static relative to the sampling clock.
 */
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else if (ce) begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* rtl/rx_fifo.sv */
/*
 * Receive elasticity FIFO, parameterised width and depth, valid/ready on both sides.
 * Assumes a single clock; DEPTH is a power of two.
 */
`timescale 1ns/1ps
module rx_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             full;
	logic             empty;

	assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
	assign empty     = (wr_reg == rd_reg);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_reg[AW-1:0]];

	// Storage array, no reset needed
	always_ff @(posedge clk) begin
		if (ce && in_valid && !full) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers; flush empties the buffer at end of frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else if (ce) begin
			if (flush) begin
				wr_reg <= '0;
				rd_reg <= '0;
			end else begin
				if (in_valid && !full) begin
					wr_reg <= wr_reg + 1'b1;
				end
				if (out_valid && out_ready) begin
					rd_reg <= rd_reg + 1'b1;
				end
			end
		end
	end
endmodule

/* rtl/mac_side_if.sv */
/*
 * MAC-facing data interface of a 10/100 PHY: MII (4-bit) or RMII (2-bit) by strap.
 * Assumes line-side nibbles arrive as a decoded stream with carrier and error flags,
 * and that the reference clock arrives as a pin, sampled by the 40 MHz core clock.
 */
`timescale 1ns/1ps
module mac_side_if (
	input  wire logic                 CLK,
	input  wire logic                 RST,
	input  wire logic                 CE,
	// Straps and control
	input  wire logic                 REDUCED_INTERFACE_SELECT_STRAP,
	input  wire logic                 CROSSOVER_AUTO_DISABLE_BIT,
	input  wire logic                 AUTONEG_ENABLE,
	input  wire logic                 FORCE_SPEED_100,
	input  wire logic                 FORCE_FULL_DUPLEX,
	input  wire logic                 NEG_SPEED_100,
	input  wire logic                 NEG_FULL_DUPLEX,
	// Line side (decoded)
	input  wire logic                 LINE_RX_BIT,
	input  wire logic                 LINE_SQUELCH_OK,
	input  wire logic                 LINE_FALSE_CARRIER,
	input  wire mac_if_pkg::rx_word_s LINE_RX_WORD,
	input  wire logic                 LINE_RX_VALID,
	input  wire logic                 LINE_RX_SFD,
	output logic                      LINE_RX_READY,
	input  wire logic                 LINE_PAIR_SEEN_ON_TX,
	output logic                      LINE_PAIRS_SWAPPED,
	output mac_if_pkg::tx_word_s      LINE_TX_WORD,
	output logic                      LINE_TX_STROBE,
	// MAC side
	input  wire logic                 REF_CLK_PIN,
	input  wire mac_if_pkg::tx_word_s MAC_TX,
	output logic                      TX_CLK_OUT,
	output logic                      RX_CLK_OUT,
	output logic [3:0]                RXD,
	output logic                      RXDV,
	output logic                      RXER,
	output logic                      CRS,
	output logic                      COL_CRS_DV,
	output logic                      SPEED_100,
	output logic                      FULL_DUPLEX
);
	logic                 rmii;
	logic                 ref_s;
	logic                 ref_d_reg;
	logic                 ref_rise;
	logic [5:0]           tx_s;
	logic                 sq_s;
	logic                 rxbit_s;
	logic [4:0]           div_reg;
	logic [4:0]           div_lim;
	logic                 tick;
	logic                 dibit_hi_reg;
	logic [9:0]           win_reg;
	logic                 carrier;
	logic                 tx_act;
	mac_if_pkg::rx_state_e st_reg;
	mac_if_pkg::rx_word_s  head;
	logic                 head_valid;
	logic                 pop;
	logic                 flush;
	logic                 swap_reg;
	logic [1:0]           tx_lo_reg;
	logic                 tx_phase_reg;
	logic                 mclk_reg;

	////////////////////////////////////////////////////////////////////
	// Reference pin, MAC transmit, squelch and line bit pass two flops before use
	sync2 #(.W(9)) u_sync (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.d   ({REF_CLK_PIN, MAC_TX, LINE_SQUELCH_OK, LINE_RX_BIT}),
		.q   ({ref_s, tx_s, sq_s, rxbit_s})
	);

	// Strap caught after reset release, held afterwards
	logic strap_done_reg;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rmii           <= 1'b0;
			strap_done_reg <= 1'b0;
		end else if (CE && !strap_done_reg) begin
			rmii           <= REDUCED_INTERFACE_SELECT_STRAP;
			strap_done_reg <= 1'b1;
		end
	end

	// Forced or negotiated speed and duplex
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			SPEED_100   <= mac_if_pkg::RST_SPEED_100;
			FULL_DUPLEX <= mac_if_pkg::RST_DUPLEX;
		end else if (CE) begin
			SPEED_100   <= AUTONEG_ENABLE ? NEG_SPEED_100 : FORCE_SPEED_100;
			FULL_DUPLEX <= AUTONEG_ENABLE ? NEG_FULL_DUPLEX : FORCE_FULL_DUPLEX;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reference edge detect on the synchronised copy only
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ref_d_reg <= 1'b0;
		end else if (CE) begin
			ref_d_reg <= ref_s;
		end
	end
	assign ref_rise = ref_s && !ref_d_reg;

	// Di-bit pacing: every ref edge at 100, every tenth at 10
	assign div_lim = SPEED_100 ? 5'(mac_if_pkg::MII_DIV_100) : 5'(mac_if_pkg::SLOW_HOLD_REFS);
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_reg <= '0;
		end else if (CE && ref_rise) begin
			div_reg <= (div_reg + 5'd1 >= div_lim) ? 5'd0 : div_reg + 5'd1;
		end
	end
	assign tick = ref_rise && (div_reg + 5'd1 >= div_lim);

	// Local MII clocks, a slow copy of the reference, usable only as a relative marker
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mclk_reg <= 1'b0;
		end else if (CE && tick) begin
			mclk_reg <= ~mclk_reg;
		end
	end
	assign TX_CLK_OUT = rmii ? 1'b0 : mclk_reg;
	assign RX_CLK_OUT = rmii ? 1'b0 : mclk_reg;

	// MII receive data moves on the falling clock edge and transmit is taken on the
	// rising one, so each nibble stands half a period around the MAC's edge
	logic rx_step;
	logic tx_step;
	assign rx_step = tick && (rmii || mclk_reg);
	assign tx_step = tick && (rmii || !mclk_reg);

	////////////////////////////////////////////////////////////////////
	// Carrier detect: 100 Mbps window of ten bits, 10 Mbps squelch
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			win_reg <= '1;
		end else if (CE) begin
			win_reg <= {win_reg[8:0], rxbit_s};
		end
	end

	// Two zeroes at least two bit positions apart anywhere in the window
	function automatic logic two_apart(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < mac_if_pkg::CARRIER_WIN_BITS; i++) begin
			for (int j = i + 2; j < mac_if_pkg::CARRIER_WIN_BITS; j++) begin
				if (!w[i] && !w[j]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	assign carrier = SPEED_100 ? two_apart(win_reg) : sq_s;
	assign tx_act  = tx_s[5];

	////////////////////////////////////////////////////////////////////
	// Receive elasticity buffer between line stream and MAC pacing
	rx_fifo #(.WIDTH(mac_if_pkg::FIFO_WIDTH + 1), .DEPTH(mac_if_pkg::FIFO_DEPTH)) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.ce        (CE),
		.flush     (flush),
		.in_data   (LINE_RX_WORD),
		.in_valid  (LINE_RX_VALID && (st_reg == mac_if_pkg::RX_DATA || LINE_RX_SFD)),
		.in_ready  (LINE_RX_READY),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (pop)
	);
	assign flush = (st_reg == mac_if_pkg::RX_IDLE) && !carrier;

	// Receive sequencing: wait for SFD, stream, drain buffer after carrier ends
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_reg <= mac_if_pkg::RX_IDLE;
		end else if (CE) begin
			case (st_reg)
				mac_if_pkg::RX_IDLE: begin
					if (carrier) begin
						st_reg <= mac_if_pkg::RX_WAIT;
					end
				end
				mac_if_pkg::RX_WAIT: begin
					if (LINE_RX_SFD && LINE_RX_VALID) begin
						st_reg <= mac_if_pkg::RX_DATA;
					end else if (!carrier && !LINE_FALSE_CARRIER) begin
						st_reg <= mac_if_pkg::RX_IDLE;
					end
				end
				mac_if_pkg::RX_DATA: begin
					if (!carrier) begin
						st_reg <= mac_if_pkg::RX_DRAIN;
					end
				end
				mac_if_pkg::RX_DRAIN: begin
					if (!head_valid && !dibit_hi_reg && tick) begin
						st_reg <= mac_if_pkg::RX_IDLE;
					end
				end
				default: begin
					st_reg <= mac_if_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Nibble position: MII pops every second tick (receive step); RMII pops after the second di-bit
	logic streaming;
	assign streaming = (st_reg == mac_if_pkg::RX_DATA) || (st_reg == mac_if_pkg::RX_DRAIN);
	assign pop       = CE && rx_step && streaming && head_valid && (!rmii || dibit_hi_reg);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			dibit_hi_reg <= 1'b0;
		end else if (CE && tick) begin
			dibit_hi_reg <= (rmii && streaming && head_valid) ? ~dibit_hi_reg : 1'b0;
		end
	end

	// Receive data outputs, updated on the receive step (every tick in RMII, every second tick in MII)
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RXD  <= 4'h0;
			RXDV <= 1'b0;
			RXER <= 1'b0;
		end else if (CE && rx_step) begin
			if (streaming && head_valid) begin
				RXD  <= rmii ? {2'b00, dibit_hi_reg ? head.data[3:2] : head.data[1:0]}
				             : head.data;
				RXDV <= !rmii;
				RXER <= head.err;
			end else begin
				RXD  <= 4'h0;
				RXDV <= 1'b0;
				RXER <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Carrier sense and collision, or CRS_DV in reduced mode
	logic crs_dv_reg;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			crs_dv_reg <= 1'b0;
		end else if (CE) begin
			if (carrier || LINE_FALSE_CARRIER) begin
				crs_dv_reg <= 1'b1;
			end else if (tick) begin
				// High on second di-bit while bits remain, low on nibble start
				// Phase flag set means this tick shows the upper di-bit
				crs_dv_reg <= streaming && head_valid && dibit_hi_reg;
			end
		end
	end

	// Combinational raise so CRS_DV follows carrier without waiting a ref edge
	always_comb begin
		if (rmii) begin
			COL_CRS_DV = crs_dv_reg || carrier || LINE_FALSE_CARRIER;
			CRS        = 1'b0;
		end else begin
			CRS        = FULL_DUPLEX ? carrier : (carrier || tx_act);
			COL_CRS_DV = !FULL_DUPLEX && carrier && tx_act;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit path: reference paced, upper bits ignored in reduced mode
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			LINE_TX_WORD   <= '0;
			LINE_TX_STROBE <= 1'b0;
			tx_lo_reg      <= 2'b00;
			tx_phase_reg   <= 1'b0;
		end else if (CE) begin
			LINE_TX_STROBE <= 1'b0;
			if (tx_step && tx_act) begin
				if (!rmii) begin
					LINE_TX_WORD   <= tx_s;
					LINE_TX_STROBE <= 1'b1;
				end else if (!tx_phase_reg) begin
					tx_lo_reg    <= tx_s[1:0];
					tx_phase_reg <= 1'b1;
				end else begin
					LINE_TX_WORD   <= {1'b1, 1'b0, tx_s[1:0], tx_lo_reg};
					LINE_TX_STROBE <= 1'b1;
					tx_phase_reg   <= 1'b0;
				end
			end else if (!tx_act) begin
				tx_phase_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pair crossover: flip when idle and partner is seen on our transmit pair
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			swap_reg <= 1'b0;
		end else if (CE) begin
			if (CROSSOVER_AUTO_DISABLE_BIT) begin
				swap_reg <= 1'b0;
			end else if (LINE_PAIR_SEEN_ON_TX && !tx_act) begin
				swap_reg <= ~swap_reg;
			end
		end
	end
	assign LINE_PAIRS_SWAPPED = swap_reg;
endmodule

/* sim/mac_side_if_chk.sv */
/* Checker on the top-level ports of the MAC-side interface.
   Assumes the strap input is held constant between resets. */
`timescale 1ns/1ps
module mac_side_if_chk (
	input wire logic                 CLK,
	input wire logic                 RST,
	input wire logic                 CE,
	input wire logic                 REDUCED_INTERFACE_SELECT_STRAP,
	input wire logic                 CROSSOVER_AUTO_DISABLE_BIT,
	input wire logic                 AUTONEG_ENABLE,
	input wire logic                 FORCE_SPEED_100,
	input wire logic                 LINE_SQUELCH_OK,
	input wire logic                 LINE_FALSE_CARRIER,
	input wire logic                 LINE_PAIRS_SWAPPED,
	input wire logic                 LINE_TX_STROBE,
	input wire mac_if_pkg::tx_word_s MAC_TX,
	input wire logic                 TX_CLK_OUT,
	input wire logic                 RX_CLK_OUT,
	input wire logic [3:0]           RXD,
	input wire logic                 CRS,
	input wire logic                 COL_CRS_DV,
	input wire logic                 SPEED_100,
	input wire logic                 FULL_DUPLEX
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	wire logic rmii = REDUCED_INTERFACE_SELECT_STRAP;

	////////////////////////////////////////////////////////////////////////////////
	// Duplex behaviour of carrier and collision
	a_fd_no_col: assert property (!rmii && FULL_DUPLEX |-> !COL_CRS_DV)
		else $error("collision seen in full duplex");
	a_hd_collide: assert property ((!rmii && !FULL_DUPLEX && !SPEED_100 && MAC_TX.en
		&& LINE_SQUELCH_OK)[*4] |-> COL_CRS_DV)
		else $error("no collision on receive during transmit");
	a_hd_carrier: assert property ((!rmii && !FULL_DUPLEX && MAC_TX.en)[*4] |-> CRS)
		else $error("carrier sense ignores transmit in half duplex");
	// Reduced mode pin usage
	a_rmii_upper: assert property (rmii |-> RXD[3:2] == 2'h0)
		else $error("upper receive bits driven in reduced mode");
	a_rmii_clocks: assert property (rmii |-> !TX_CLK_OUT && !RX_CLK_OUT)
		else $error("clock outputs run in reduced mode");
	a_false_carrier: assert property ((rmii && LINE_FALSE_CARRIER)[*3] |-> COL_CRS_DV)
		else $error("valid dropped during false carrier");
	// Control paths
	a_strobe_pulse: assert property (LINE_TX_STROBE |=> !LINE_TX_STROBE)
		else $error("transmit strobe longer than one cycle");
	a_xover_off: assert property (CROSSOVER_AUTO_DISABLE_BIT
		&& $past(CROSSOVER_AUTO_DISABLE_BIT) |-> !LINE_PAIRS_SWAPPED)
		else $error("pairs swapped while crossover disabled");
	a_speed_forced: assert property ((!AUTONEG_ENABLE && CE && $stable(FORCE_SPEED_100))[*4]
		|-> SPEED_100 == FORCE_SPEED_100)
		else $error("speed does not follow forced bit");
endmodule

bind mac_side_if mac_side_if_chk chk_u (
	.CLK                            (CLK),
	.RST                            (RST),
	.CE                             (CE),
	.REDUCED_INTERFACE_SELECT_STRAP (REDUCED_INTERFACE_SELECT_STRAP),
	.CROSSOVER_AUTO_DISABLE_BIT     (CROSSOVER_AUTO_DISABLE_BIT),
	.AUTONEG_ENABLE                 (AUTONEG_ENABLE),
	.FORCE_SPEED_100                (FORCE_SPEED_100),
	.LINE_SQUELCH_OK                (LINE_SQUELCH_OK),
	.LINE_FALSE_CARRIER             (LINE_FALSE_CARRIER),
	.LINE_PAIRS_SWAPPED             (LINE_PAIRS_SWAPPED),
	.LINE_TX_STROBE                 (LINE_TX_STROBE),
	.MAC_TX                         (MAC_TX),
	.TX_CLK_OUT                     (TX_CLK_OUT),
	.RX_CLK_OUT                     (RX_CLK_OUT),
	.RXD                            (RXD),
	.CRS                            (CRS),
	.COL_CRS_DV                     (COL_CRS_DV),
	.SPEED_100                      (SPEED_100),
	.FULL_DUPLEX                    (FULL_DUPLEX)
);

/* sim/mac_model.sv */
/* MAC controller model on the far side of the interface.
   Assumes the block's clocks arrive as plain outputs and the strap selects RMII. */
`timescale 1ns/1ps
module mac_model (
	input  wire logic            rmii,
	input  wire logic            tx_req,
	input  wire logic            TX_CLK_OUT,
	input  wire logic            RX_CLK_OUT,
	input  wire logic            REF_CLK_PIN,
	input  wire logic [3:0]      RXD,
	input  wire logic            RXDV,
	input  wire logic            RXER,
	input  wire logic            COL_CRS_DV,
	output mac_if_pkg::tx_word_s mac_tx
);
	logic [4:0] rx_q[$];
	logic [1:0] di_q[$];
	logic [5:0] tx_q[$];
	logic       dv_last = 1'b0;
	wire logic  tx_edge = rmii ? REF_CLK_PIN : TX_CLK_OUT;

	initial mac_tx = '0;
	// Launch after the clock rise; idle data inverted so it never looks held
	always @(posedge tx_edge) begin : launch
		logic [3:0] nxt;
		nxt = tx_req ? mac_tx.data + 4'h1 : ~mac_tx.data;
		if (rmii)
			nxt[3:2] = 2'h0;
		mac_tx <= {tx_req, 1'b0, nxt};
		// MII nibbles kept so the bench can follow them onto the line
		if (tx_req && !rmii)
			tx_q.push_back({tx_req, 1'b0, nxt});
	end
	// Nibble taken at receive clock rise only while valid
	always @(posedge RX_CLK_OUT)
		if (RXDV)
			rx_q.push_back({RXER, RXD});
	// Di-bits kept while valid is high and through its toggling tail
	always @(posedge REF_CLK_PIN)
		if (rmii) begin
			if (COL_CRS_DV || dv_last)
				di_q.push_back(RXD[1:0]);
			dv_last = COL_CRS_DV;
		end
endmodule

/* sim/test_mac_side_if.sv */
/* Bench: duplex, crossover, FIFO refusal, MII and RMII receive.
   Assumes the MAC model and a free-running 200 ns reference pin. */
`timescale 1ns/1ps
module test_mac_side_if;
	logic clk = 1'b0, rst = 1'b1, strap = 1'b0, xdis = 1'b0, an = 1'b0, fspd = 1'b0;
	logic ffd = 1'b0, rbit = 1'b1, sq = 1'b0, fc = 1'b0, wval = 1'b0, sfd = 1'b0;
	logic pair = 1'b0, refc = 1'b0, txr = 1'b0;
	logic rdy, swp, txc, rxc, rxdv, rxer, crs, col, spd, fdx, txs;
	logic [3:0]           rxd;
	logic [4:0]           exp_q[$];
	mac_if_pkg::rx_word_s word = '0;
	mac_if_pkg::tx_word_s mtx, txw;
	int                   mismatches = 0;
	int                   check_count = 0;
	int                   cyc = 0;
	int                   seed = 32'hBBD0C333;

	mac_side_if dut_u (
		.CLK(clk), .RST(rst), .CE(1'b1), .REDUCED_INTERFACE_SELECT_STRAP(strap),
		.CROSSOVER_AUTO_DISABLE_BIT(xdis), .AUTONEG_ENABLE(an), .FORCE_SPEED_100(fspd),
		.FORCE_FULL_DUPLEX(ffd), .NEG_SPEED_100(1'b0), .NEG_FULL_DUPLEX(1'b1),
		.LINE_RX_BIT(rbit), .LINE_SQUELCH_OK(sq), .LINE_FALSE_CARRIER(fc), .LINE_RX_WORD(word),
		.LINE_RX_VALID(wval), .LINE_RX_SFD(sfd), .LINE_RX_READY(rdy),
		.LINE_PAIR_SEEN_ON_TX(pair), .LINE_PAIRS_SWAPPED(swp), .LINE_TX_WORD(txw),
		.LINE_TX_STROBE(txs), .REF_CLK_PIN(refc), .MAC_TX(mtx), .TX_CLK_OUT(txc),
		.RX_CLK_OUT(rxc), .RXD(rxd), .RXDV(rxdv), .RXER(rxer), .CRS(crs), .COL_CRS_DV(col),
		.SPEED_100(spd), .FULL_DUPLEX(fdx)
	);
	mac_model m (
		.rmii(strap), .tx_req(txr), .TX_CLK_OUT(txc), .RX_CLK_OUT(rxc), .REF_CLK_PIN(refc),
		.RXD(rxd), .RXDV(rxdv), .RXER(rxer), .COL_CRS_DV(col), .mac_tx(mtx)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Core clock, and a reference pin of unrelated phase
	always #12.5 clk = ~clk;
	initial begin
		#37;
		forever #100 refc = ~refc;
	end
	// Every nibble the MAC launched in MII leaves on the line once, in order
	always @(posedge clk)
		if (txs === 1'b1 && !strap)
			check(8'(txw), (m.tx_q.size() > 0) ? 8'(m.tx_q.pop_front()) : 8'hFF);
	// Alternating line bits give spaced zeroes while carrier is wanted
	always @(posedge clk)
		rbit <= sq ? ~rbit : 1'b1;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		rst <= 1'b1;
		strap <= s;
		w(6);
		rst <= 1'b0;
		w(2);
	endtask
	// One refused word before the delimiter, then n words; the bench queues what was taken
	task automatic send(input int n, output logic full);
		int i;
		logic [4:0] v;
		full = 1'b0;
		sq <= 1'b1;
		// The 100 Mbps window needs two spaced zeroes before the delimiter goes out
		w(8);
		for (i = -1; i < n; i++) begin
			v = (i < 1) ? 5'h0D : 5'($random(seed));
			word <= v;
			wval <= 1'b1;
			sfd <= (i == 0);
			@(negedge clk);
			if (i >= 0 && rdy === 1'b1)
				exp_q.push_back(v);
			full = full | (rdy !== 1'b1);
			@(posedge clk);
		end
		wval <= 1'b0;
		sfd <= 1'b0;
		sq <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic full;
		logic [1:0] lo, hi;
		logic [4:0] v;
		do_reset(1'b0);
		// Half then full duplex at 10 Mbps with transmit running
		txr <= 1'b1;
		w(260);
		check(8'(crs), 8'h01);
		sq <= 1'b1;
		w(8);
		check(8'(col), 8'h01);
		ffd <= 1'b1;
		w(8);
		check(8'(col), 8'h00);
		sq <= 1'b0;
		w(8);
		check(8'(crs), 8'h00);
		txr <= 1'b0;
		ffd <= 1'b0;
		an <= 1'b1;
		w(8);
		check({6'h00, fdx, spd}, 8'h02);
		// Full-rate MII transmit while the bench follows every nibble
		an <= 1'b0;
		fspd <= 1'b1;
		txr <= 1'b1;
		w(260);
		txr <= 1'b0;
		w(40);
		fspd <= 1'b0;
		w(8);
		// Crossover toggles on detect, stays straight when disabled
		pair <= 1'b1;
		w(1);
		pair <= 1'b0;
		w(6);
		check(8'(swp), 8'h01);
		xdis <= 1'b1;
		w(1);
		pair <= 1'b1;
		w(1);
		pair <= 1'b0;
		w(6);
		check(8'(swp), 8'h00);
		// Flood the buffer past full at 10 Mbps, then drain through MII
		send(40, full);
		check(8'(full), 8'h01);
		for (i = 0; i < 8000 && m.rx_q.size() < exp_q.size(); i++)
			@(posedge clk);
		check(8'(m.rx_q.size()), 8'(exp_q.size()));
		while (exp_q.size() > 0 && m.rx_q.size() > 0)
			check(8'(m.rx_q.pop_front()), 8'(exp_q.pop_front()));
		exp_q.delete();
		// Reduced mode at 100 Mbps
		do_reset(1'b1);
		fspd <= 1'b1;
		w(8);
		fc <= 1'b1;
		w(4);
		for (i = 0; i < 16; i++) begin
			@(negedge clk);
			check(8'(col), 8'h01);
		end
		@(posedge clk);
		fc <= 1'b0;
		w(100);
		m.di_q.delete();
		send(6, full);
		w(500);
		check(8'(col), 8'h00);
		while (m.di_q.size() > 0 && m.di_q[0] === 2'h0)
			void'(m.di_q.pop_front());
		check(8'(m.di_q.size() >= 2 * exp_q.size()), 8'h01);
		while (exp_q.size() > 0 && m.di_q.size() > 1) begin
			v = exp_q.pop_front();
			lo = m.di_q.pop_front();
			hi = m.di_q.pop_front();
			check({4'h0, hi, lo}, {4'h0, v[3:0]});
		end
		print_verdict();
	end
endmodule
